// File: scif_pkg.sv
// Shared constants for the instrument-side spacecraft signal interface.
// Assumes one 200 MHz system clock and inputs already synchronous to it.
package scif_pkg;

    // ------------------------------------------------------------------
    // System clock and serial link timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned BAUD_RATE = 38_400;
    // One bit time in clock cycles, rounded down (about 0.006 % fast).
    localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
    localparam int unsigned BIT_CNT_W = 13;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam int unsigned FRAME_BITS = 11;
    localparam logic [3:0] LAST_FRAME_BIT = 4'hA;

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    localparam int unsigned FAST_TIME_CLOCK_RATE = 1_048_576;
    localparam int unsigned SUBSEC_W = 20;
    localparam logic [SUBSEC_W-1:0] SUBSEC_LAST = 20'hFFFFF;
    localparam logic [SUBSEC_W-1:0] SUBSEC_RST = 20'h00000;
    localparam int unsigned SEC_W = 32;
    localparam logic [SEC_W-1:0] SEC_RST = 32'h00000000;

endpackage : scif_pkg

// File: scif_uart_rx.sv
// Command line receiver: start, eight data bits LSB first, even parity, stop.
// Assumes the serial input is idle high and synchronous to the clock.
`timescale 1ns/1ps
module scif_uart_rx #(
    parameter logic [12:0] BIT_CYCLES = 13'h1458
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic soft_rst_i,
    input wire logic rx_i,
    output logic [7:0] byte_o,
    output logic valid_o,
    output logic parity_err_o,
    output logic frame_err_o
);
    import scif_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} scif_rx_state_t;

    scif_rx_state_t state_r, state_nxt;
    logic [12:0] cnt_r, cnt_nxt;
    logic [2:0] bitn_r, bitn_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic par_r, par_nxt;
    logic done_w;
    logic stop_now_w;
    logic [12:0] half_w;

    // ------------------------------------------------------------------
    // Bit timing decode
    // ------------------------------------------------------------------
    // Sampling at mid-bit tolerates clock error on either side equally.
    assign done_w = (cnt_r == 13'h0000);
    assign half_w = BIT_CYCLES >> 1;
    assign stop_now_w = (state_r == RX_STOP) && done_w;

    // Next-state logic for the frame walk.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = done_w ? cnt_r : cnt_r - 13'h0001;
        bitn_nxt = bitn_r;
        shift_nxt = shift_r;
        par_nxt = par_r;
        unique case (state_r)
            RX_IDLE: begin
                if (!rx_i) begin
                    state_nxt = RX_START;
                    cnt_nxt = half_w - 13'h0001;
                end
            end
            RX_START: begin
                // A start bit that is gone at mid-bit was a glitch.
                if (done_w) begin
                    state_nxt = rx_i ? RX_IDLE : RX_DATA;
                    cnt_nxt = BIT_CYCLES - 13'h0001;
                    bitn_nxt = 3'h0;
                end
            end
            RX_DATA: begin
                if (done_w) begin
                    shift_nxt = {rx_i, shift_r[7:1]};
                    cnt_nxt = BIT_CYCLES - 13'h0001;
                    bitn_nxt = bitn_r + 3'h1;
                    if (bitn_r == LAST_DATA_BIT) begin
                        state_nxt = RX_PARITY;
                    end
                end
            end
            RX_PARITY: begin
                if (done_w) begin
                    par_nxt = rx_i;
                    cnt_nxt = BIT_CYCLES - 13'h0001;
                    state_nxt = RX_STOP;
                end
            end
            RX_STOP: begin
                if (done_w) begin
                    state_nxt = RX_IDLE;
                end
            end
        endcase
    end

    // State registers; the soft reset puts the receiver back to idle.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= RX_IDLE;
            cnt_r <= 13'h0000;
            bitn_r <= 3'h0;
            shift_r <= 8'h00;
            par_r <= 1'b0;
        end else if (soft_rst_i) begin
            state_r <= RX_IDLE;
            cnt_r <= 13'h0000;
            bitn_r <= 3'h0;
            shift_r <= 8'h00;
            par_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bitn_r <= bitn_nxt;
            shift_r <= shift_nxt;
            par_r <= par_nxt;
        end
    end

    // Byte delivery with its error flags, all registered.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            byte_o <= 8'h00;
            valid_o <= 1'b0;
            parity_err_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            valid_o <= stop_now_w && !soft_rst_i;
            if (stop_now_w && !soft_rst_i) begin
                byte_o <= shift_r;
                parity_err_o <= (^shift_r) ^ par_r;
                frame_err_o <= !rx_i;
            end
        end
    end

endmodule // scif_uart_rx

// File: scif_top.sv
// Instrument-side time base, reset, safe mode and low-speed serial links.
// Assumes every input is synchronous to ref_clk_i; the fast time clock and
// the seconds tick are sampled as ordinary inputs at 200 MHz.
`timescale 1ns/1ps

module scif_top #(
    parameter logic [12:0] BIT_CYCLES = 13'(scif_pkg::BIT_CYCLES_DEF)
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sec_tick_i,
    input wire logic fast_clk_i,
    input wire logic sc_reset_i,
    input wire logic safe_req_i,
    input wire logic safe_exit_i,
    input wire logic science_req_i,
    input wire logic time_load_i,
    input wire logic [scif_pkg::SEC_W-1:0] time_load_sec_i,
    input wire logic cmd_rx_i,
    input wire logic tlm_valid_i,
    input wire logic [7:0] tlm_data_i,
    output logic tlm_ready_o,
    output logic tlm_tx_o,
    output logic [7:0] cmd_byte_o,
    output logic cmd_valid_o,
    output logic cmd_parity_err_o,
    output logic cmd_frame_err_o,
    output logic [scif_pkg::SEC_W-1:0] seconds_o,
    output logic [scif_pkg::SUBSEC_W-1:0] subsec_o,
    output logic time_mark_o,
    output logic tick_count_err_o,
    output logic safe_mode_o,
    output logic cooler_power_en_o,
    output logic science_en_o
);
    import scif_pkg::*;

    typedef enum logic {TX_IDLE, TX_SEND} scif_tx_state_t;

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    logic fast_q_r;
    logic fast_rise_w;
    logic mark_w;
    logic [SUBSEC_W-1:0] subsec_r;
    logic [SEC_W-1:0] seconds_r;
    logic load_pend_r;
    logic [SEC_W-1:0] load_val_r;
    logic [SEC_W-1:0] seconds_nxt;

    // The tick is one fast half period wide, so it always straddles exactly
    // one fast rising edge; that edge alone is the second.
    assign fast_rise_w = fast_clk_i && !fast_q_r;
    assign mark_w = fast_rise_w && sec_tick_i;
    assign seconds_nxt = load_pend_r ? load_val_r : seconds_r + 32'h00000001;

    // Edge history of the fast time clock.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fast_q_r <= 1'b0;
        end else begin
            fast_q_r <= fast_clk_i;
        end
    end

    // Subsecond counter wraps on each mark; seconds advance or take the load.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            subsec_r <= SUBSEC_RST;
            seconds_r <= SEC_RST;
            time_mark_o <= 1'b0;
            tick_count_err_o <= 1'b0;
        end else if (sc_reset_i) begin
            subsec_r <= SUBSEC_RST;
            seconds_r <= SEC_RST;
            time_mark_o <= 1'b0;
            tick_count_err_o <= 1'b0;
        end else begin
            time_mark_o <= mark_w;
            tick_count_err_o <= mark_w && (subsec_r != SUBSEC_LAST);
            if (mark_w) begin
                subsec_r <= SUBSEC_RST;
                seconds_r <= seconds_nxt;
            end else if (fast_rise_w) begin
                subsec_r <= subsec_r + 20'h00001;
            end
        end
    end

    // Pending time load; a new load in the mark cycle is kept, not lost.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_pend_r <= 1'b0;
            load_val_r <= SEC_RST;
        end else if (sc_reset_i) begin
            load_pend_r <= 1'b0;
            load_val_r <= SEC_RST;
        end else if (time_load_i) begin
            load_pend_r <= 1'b1;
            load_val_r <= time_load_sec_i;
        end else if (mark_w) begin
            load_pend_r <= 1'b0;
        end
    end

    assign seconds_o = seconds_r;
    assign subsec_o = subsec_r;

    // ------------------------------------------------------------------
    // Safe mode
    // ------------------------------------------------------------------
    // The request is a level held for seconds, so one sample suffices; the
    // state latches so a short dip of the request changes nothing.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            safe_mode_o <= 1'b0;
            cooler_power_en_o <= 1'b0;
            science_en_o <= 1'b0;
        end else if (sc_reset_i) begin
            safe_mode_o <= 1'b0;
            cooler_power_en_o <= 1'b0;
            science_en_o <= 1'b0;
        end else begin
            if (safe_req_i) begin
                safe_mode_o <= 1'b1;
            end else if (safe_exit_i) begin
                safe_mode_o <= 1'b0;
            end
            cooler_power_en_o <= !(safe_req_i || safe_mode_o);
            science_en_o <= science_req_i && !(safe_req_i || safe_mode_o);
        end
    end

    // ------------------------------------------------------------------
    // Command receiver
    // ------------------------------------------------------------------
    scif_uart_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_cmd_rx (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .soft_rst_i(sc_reset_i),
        .rx_i(cmd_rx_i),
        .byte_o(cmd_byte_o),
        .valid_o(cmd_valid_o),
        .parity_err_o(cmd_parity_err_o),
        .frame_err_o(cmd_frame_err_o)
    );

    // ------------------------------------------------------------------
    // Telemetry transmitter
    // ------------------------------------------------------------------
    scif_tx_state_t tx_state_r;
    logic [12:0] tx_cnt_r;
    logic [3:0] tx_bitn_r;
    logic [FRAME_BITS-1:0] tx_frame_r;
    logic tx_take_w;
    logic tx_bit_end_w;
    logic [FRAME_BITS-1:0] tx_load_w;

    // Frame is stop, even parity, data, start; shifted out LSB first.
    assign tx_load_w = {1'b1, ^tlm_data_i, tlm_data_i, 1'b0};
    assign tx_take_w = tlm_valid_i && tlm_ready_o;
    assign tx_bit_end_w = (tx_cnt_r == 13'h0000);

    // One byte in flight; ready stays low until its stop bit has ended.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_state_r <= TX_IDLE;
            tx_cnt_r <= 13'h0000;
            tx_bitn_r <= 4'h0;
            tx_frame_r <= '1;
            tlm_tx_o <= 1'b1;
            tlm_ready_o <= 1'b0;
        end else if (sc_reset_i) begin
            tx_state_r <= TX_IDLE;
            tx_cnt_r <= 13'h0000;
            tx_bitn_r <= 4'h0;
            tx_frame_r <= '1;
            tlm_tx_o <= 1'b1;
            tlm_ready_o <= 1'b0;
        end else begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    tlm_ready_o <= !tx_take_w;
                    if (tx_take_w) begin
                        tx_state_r <= TX_SEND;
                        tx_frame_r <= tx_load_w >> 1;
                        tlm_tx_o <= tx_load_w[0];
                        tx_cnt_r <= BIT_CYCLES - 13'h0001;
                        tx_bitn_r <= 4'h0;
                    end
                end
                TX_SEND: begin
                    if (!tx_bit_end_w) begin
                        tx_cnt_r <= tx_cnt_r - 13'h0001;
                    end else if (tx_bitn_r == LAST_FRAME_BIT) begin
                        tx_state_r <= TX_IDLE;
                        tlm_tx_o <= 1'b1;
                        tlm_ready_o <= 1'b1;
                    end else begin
                        tlm_tx_o <= tx_frame_r[0];
                        tx_frame_r <= {1'b1, tx_frame_r[FRAME_BITS-1:1]};
                        tx_cnt_r <= BIT_CYCLES - 13'h0001;
                        tx_bitn_r <= tx_bitn_r + 4'h1;
                    end
                end
            endcase
        end
    end

endmodule // scif_top

// File: scif_sc_model.sv
// Spacecraft-side model: fast time wave, seconds tick and command sender.
// Assumes run_i stays low through reset; the bench calls send() on a falling edge.
`timescale 1ns/1ps
module scif_sc_model #(
    parameter int HALF = 4,
    parameter int PER_SEC = 5,
    parameter int BIT = 16
) (
    input wire logic ref_clk_i,
    input wire logic run_i,
    output logic fast_clk_o,
    output logic sec_tick_o,
    output logic cmd_tx_o
);
    // ------------------------------------------------------------------
    // Time clocks
    // ------------------------------------------------------------------
    int ph = 0;
    initial cmd_tx_o = 1'h1;
    // The phase counter moves on the falling edge so nothing races the sampler.
    always @(negedge ref_clk_i) begin
        ph <= run_i ? (ph + 1) % (2 * HALF * PER_SEC) : 0;
    end
    // A whole number of fast periods per second, so the count never slips.
    assign fast_clk_o = run_i && (ph % (2 * HALF)) >= HALF;
    // The tick is half a fast period wide and straddles exactly one fast rise.
    assign sec_tick_o = run_i && ph >= HALF - 2 && ph < HALF + 2;

    // ------------------------------------------------------------------
    // Command sender
    // ------------------------------------------------------------------
    // The error flags corrupt one field only, so each receiver flag is seen alone.
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] fr;
        fr = {~bad_stop, ^d ^ bad_par, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            cmd_tx_o = fr[i];
            repeat (BIT) @(negedge ref_clk_i);
        end
        cmd_tx_o = 1'h1;
    endtask
endmodule // scif_sc_model

// File: scif_top_asserts.sv
// Checker for the instrument-side signal interface, bound to scif_top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module scif_top_asserts (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic sec_tick_i,
    input wire logic fast_clk_i,
    input wire logic sc_reset_i,
    input wire logic safe_req_i,
    input wire logic safe_exit_i,
    input wire logic science_req_i,
    input wire logic cmd_rx_i,
    input wire logic tlm_valid_i,
    input wire logic tlm_ready_o,
    input wire logic tlm_tx_o,
    input wire logic cmd_valid_o,
    input wire logic cmd_frame_err_o,
    input wire logic time_mark_o,
    input wire logic tick_count_err_o,
    input wire logic safe_mode_o,
    input wire logic cooler_power_en_o,
    input wire logic science_en_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // A mark is a sampled fast rise while the tick is high.
    sequence s_rise_tick;
        fast_clk_i && !$past(fast_clk_i) && sec_tick_i;
    endsequence
    // The ground reset holds the time mark low, so its cycles and the one after are left out.
    sequence s_quiet;
        !sc_reset_i && !$past(sc_reset_i);
    endsequence
    a_mark_after_rise: assert property (s_rise_tick ##0 s_quiet |=> time_mark_o)
        else $error("time mark missing after tick rise");
    a_mark_needs_tick: assert property (time_mark_o |-> $past(sec_tick_i))
        else $error("time mark without tick");
    a_count_err_mark: assert property (tick_count_err_o |-> time_mark_o)
        else $error("count error outside a mark");
    a_safe_enter: assert property (safe_req_i && !sc_reset_i |=> safe_mode_o)
        else $error("safe request not taken");
    a_safe_sticky: assert property (safe_mode_o && !safe_exit_i && !sc_reset_i |=> safe_mode_o)
        else $error("safe mode left without exit");
    a_safe_leave: assert property (safe_mode_o && safe_exit_i && !safe_req_i |=> !safe_mode_o)
        else $error("safe exit ignored");
    a_safe_loads_off: assert property (safe_mode_o |-> !cooler_power_en_o && !science_en_o)
        else $error("loads on in safe mode");
    a_science_on: assert property (science_req_i && !safe_req_i && !safe_mode_o && !sc_reset_i |=> science_en_o)
        else $error("science not enabled");
    a_tlm_start: assert property (tlm_valid_i && tlm_ready_o && !sc_reset_i |=> !tlm_tx_o && !tlm_ready_o)
        else $error("telemetry start bit missing");
    a_tlm_idle_high: assert property (tlm_ready_o |-> tlm_tx_o)
        else $error("telemetry line not idle high");
    a_stop_flag: assert property (cmd_valid_o |-> cmd_frame_err_o == !$past(cmd_rx_i, 2))
        else $error("stop error flag wrong");
endmodule // scif_top_asserts

bind scif_top scif_top_asserts scif_top_asserts_i (.ref_clk_i, .rstn_i, .sec_tick_i, .fast_clk_i,
    .sc_reset_i, .safe_req_i, .safe_exit_i, .science_req_i, .cmd_rx_i, .tlm_valid_i, .tlm_ready_o,
    .tlm_tx_o, .cmd_valid_o, .cmd_frame_err_o, .time_mark_o, .tick_count_err_o, .safe_mode_o,
    .cooler_power_en_o, .science_en_o);

// File: scif_top_tb.sv
// Self-checking bench for scif_top with a short bit time and a short second.
// Assumes scif_sc_model drives the time lines and the command line.
`timescale 1ns/1ps
module scif_top_tb;
    import scif_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam int PER_SEC = 5;
    logic ref_clk_i = 1'h0, rstn_i = 1'h0, run = 1'h0, sc_reset_i = 1'h0, safe_req_i = 1'h0;
    logic safe_exit_i = 1'h0, science_req_i = 1'h0, time_load_i = 1'h0, tlm_valid_i = 1'h0;
    logic [SEC_W-1:0] time_load_sec_i = '0, seconds_o;
    logic [7:0] tlm_data_i = '0, cmd_byte_o;
    logic [SUBSEC_W-1:0] subsec_o;
    logic sec_tick_i, fast_clk_i, cmd_rx_i, tlm_ready_o, tlm_tx_o, cmd_valid_o, cmd_parity_err_o;
    logic cmd_frame_err_o, time_mark_o, tick_count_err_o, safe_mode_o, cooler_power_en_o, science_en_o;
    int n_errors = 0;
    int cmp_count = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    scif_top #(.BIT_CYCLES(13'h0010)) scif_top_i (.ref_clk_i, .rstn_i, .sec_tick_i, .fast_clk_i,
        .sc_reset_i, .safe_req_i, .safe_exit_i, .science_req_i, .time_load_i, .time_load_sec_i,
        .cmd_rx_i, .tlm_valid_i, .tlm_data_i, .tlm_ready_o, .tlm_tx_o, .cmd_byte_o, .cmd_valid_o,
        .cmd_parity_err_o, .cmd_frame_err_o, .seconds_o, .subsec_o, .time_mark_o, .tick_count_err_o,
        .safe_mode_o, .cooler_power_en_o, .science_en_o);
    scif_sc_model #(.HALF(4), .PER_SEC(PER_SEC), .BIT(16)) scif_sc_model_i (.ref_clk_i, .run_i(run),
        .fast_clk_o(fast_clk_i), .sec_tick_o(sec_tick_i), .cmd_tx_o(cmd_rx_i));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Returns on the cycle the mark shows, with the subsecond count seen just before it.
    task automatic wait_mark(output logic [SUBSEC_W-1:0] pre);
        cyc(1);
        pre = subsec_o;
        for (int i = 0; i < 200 && time_mark_o !== 1'h1; i++) begin
            pre = subsec_o;
            cyc(1);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_time;
        logic [SUBSEC_W-1:0] pre;
        wait_mark(pre);
        chk("mark", time_mark_o, 32'h1);
        chk("seconds", seconds_o, 32'h1);
        chk("subsec", subsec_o, 32'h0);
        wait_mark(pre);
        chk("subsec at mark", pre, PER_SEC - 1);
        chk("count err", tick_count_err_o, 32'h1);
        chk("seconds next", seconds_o, 32'h2);
        time_load_sec_i = 32'h0000ABCD;
        time_load_i = 1'h1;
        cyc(1);
        time_load_i = 1'h0;
        wait_mark(pre);
        chk("loaded", seconds_o, 32'h0000ABCD);
        wait_mark(pre);
        chk("after load", seconds_o, 32'h0000ABCE);
    endtask
    task automatic t_safe;
        chk("science idle", science_en_o, 32'h0);
        chk("cooler idle", cooler_power_en_o, 32'h1);
        science_req_i = 1'h1;
        safe_req_i = 1'h1;
        cyc(1);
        chk("safe on", safe_mode_o, 32'h1);
        chk("cooler off", cooler_power_en_o, 32'h0);
        chk("science off", science_en_o, 32'h0);
        // The request stands for two of the bench's short seconds.
        cyc(2 * 8 * PER_SEC);
        safe_exit_i = 1'h1;
        cyc(1);
        chk("exit refused", safe_mode_o, 32'h1);
        safe_req_i = 1'h0;
        safe_exit_i = 1'h0;
        cyc(2);
        chk("safe held", safe_mode_o, 32'h1);
        safe_exit_i = 1'h1;
        cyc(1);
        safe_exit_i = 1'h0;
        chk("safe off", safe_mode_o, 32'h0);
        cyc(1);
        chk("cooler back", cooler_power_en_o, 32'h1);
        chk("science back", science_en_o, 32'h1);
    endtask
    // Bits 9 and 8 of each entry ask for a bad stop and a bad parity bit.
    task automatic t_cmd;
        logic [9:0] tv [3] = '{10'h0A5, 10'h13C, 10'h201};
        for (int k = 0; k < 3; k++) begin
            fork
                scif_sc_model_i.send(tv[k][7:0], tv[k][8], tv[k][9]);
                begin
                    for (int i = 0; i < 400 && cmd_valid_o !== 1'h1; i++) cyc(1);
                    chk("cmd byte", cmd_byte_o, tv[k][7:0]);
                    chk("parity err", cmd_parity_err_o, tv[k][8]);
                    chk("frame err", cmd_frame_err_o, tv[k][9]);
                end
            join
        end
    endtask
    // Samples every bit at its middle, sixteen cycles apart.
    task automatic t_tlm(input logic [7:0] d);
        logic [10:0] fr;
        fr = {1'h1, ^d, d, 1'h0};
        tlm_data_i = d;
        tlm_valid_i = 1'h1;
        for (int i = 0; i < 400 && tlm_ready_o !== 1'h1; i++) cyc(1);
        cyc(1);
        tlm_valid_i = 1'h0;
        cyc(7);
        for (int i = 0; i < 11; i++) begin
            chk("tlm bit", tlm_tx_o, fr[i]);
            cyc(16);
        end
        chk("tlm ready", tlm_ready_o, 32'h1);
    endtask
    task automatic t_screset;
        safe_req_i = 1'h1;
        cyc(1);
        safe_req_i = 1'h0;
        // The ground reset pulse is shortened to two cycles for the bench.
        sc_reset_i = 1'h1;
        cyc(2);
        chk("reset safe", safe_mode_o, 32'h0);
        chk("reset seconds", seconds_o, 32'h0);
        chk("reset ready", tlm_ready_o, 32'h0);
        chk("reset cooler", cooler_power_en_o, 32'h0);
        sc_reset_i = 1'h0;
        cyc(1);
        chk("ready after", tlm_ready_o, 32'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        cyc(2);
        chk("tx in reset", tlm_tx_o, 32'h1);
        rstn_i = 1'h1;
        cyc(1);
        run = 1'h1;
        t_time();
        t_safe();
        t_cmd();
        t_tlm(8'h96);
        t_tlm(8'h01);
        t_screset();
        close_out();
    end
    // The whole run needs about 1100 cycles; this leaves wide margin.
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule // scif_top_tb
